// ---- hw/supply_monitor_flag_logic.sv ----
// Control and status logic of the dual-supply voltage monitor
`timescale 1ns/1ps
`include "supply_monitor_params.svh"

module supply_monitor_flag_logic #(
  parameter int unsigned RELEASE_CYC = `SMON_RELEASE_CYC,
  parameter int unsigned GLITCH_CYC = `SMON_GLITCH_CYC
) (
  input wire logic ref_clk_i, // Core clock, 250 MHz
  input wire logic reset_n_i, // Synchronous reset, active low
  input wire supply_monitor_pkg::sfr_req_t sfr_req_i, // SFR address, write strobe, data
  output logic [7:0] sfr_rdata_o, // SFR read data, zero when not addressed
  input wire logic digital_supply_cmp_i, // Digital comparator, 1 when above trip
  input wire logic analog_supply_cmp_i, // Analog comparator, 1 when above trip
  input wire logic irq_enable_i, // Interrupt enable from irq_enable_priority_two, gates irq_o only
  output supply_monitor_pkg::comp_ctrl_t comp_ctrl_o, // Trip selects and enable to comparators
  output logic irq_o // Interrupt request, level
);
  import supply_monitor_pkg::*;

  localparam int unsigned RW = $clog2(RELEASE_CYC + 1);
  localparam int unsigned GW = $clog2(GLITCH_CYC + 1);

  typedef struct packed {
    logic [1:0] dig_sync;
    logic [1:0] ana_sync;
    logic [GW-1:0] dig_cnt;
    logic [GW-1:0] ana_cnt;
    logic dig_ok;
    logic ana_ok;
    logic fault;
    trip_level_t dig_trip;
    trip_level_t ana_trip;
    logic enable;
    logic [RW-1:0] rel_cnt;
    logic [7:0] rdata;
    logic irq;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic wr_hit;
  logic both_ok;

  always_comb begin
    st_nxt = st_r;
    wr_hit = sfr_req_i.wr && (sfr_req_i.addr == `SMON_REG_ADDR);
    // Second stage only feeds the filters below
    st_nxt.dig_sync = {st_r.dig_sync[0], digital_supply_cmp_i};
    st_nxt.ana_sync = {st_r.ana_sync[0], analog_supply_cmp_i};
    // Low must persist the whole window before the status drops; rising is immediate
    if (st_r.dig_sync[1]) begin
      st_nxt.dig_cnt = '0;
      st_nxt.dig_ok = 1'b1;
    end else if (st_r.dig_cnt >= GW'(GLITCH_CYC)) begin
      st_nxt.dig_ok = 1'b0;
    end else begin
      st_nxt.dig_cnt = st_r.dig_cnt + GW'(1);
    end
    if (st_r.ana_sync[1]) begin
      st_nxt.ana_cnt = '0;
      st_nxt.ana_ok = 1'b1;
    end else if (st_r.ana_cnt >= GW'(GLITCH_CYC)) begin
      st_nxt.ana_ok = 1'b0;
    end else begin
      st_nxt.ana_cnt = st_r.ana_cnt + GW'(1);
    end
    // A disabled monitor counts as healthy for the fault flag and raises nothing; the status bits still follow the comparators
    both_ok = (st_r.dig_ok && st_r.ana_ok) || !st_r.enable;
    if (wr_hit) begin
      st_nxt.dig_trip = trip_level_t'(sfr_req_i.wdata[`SMON_BIT_DTRIP_HI:`SMON_BIT_DTRIP_LO]);
      st_nxt.ana_trip = trip_level_t'(sfr_req_i.wdata[`SMON_BIT_ATRIP_HI:`SMON_BIT_ATRIP_LO]);
      st_nxt.enable = sfr_req_i.wdata[`SMON_BIT_ON];
      if (sfr_req_i.wdata[`SMON_BIT_FAULT] || both_ok) begin
        st_nxt.fault = sfr_req_i.wdata[`SMON_BIT_FAULT];
      end
    end
    if (!both_ok) begin
      st_nxt.fault = 1'b1;
      st_nxt.rel_cnt = '0;
    end else if (st_nxt.fault) begin
      // Counts while the flag stands; expiry is the only hardware clear
      if (st_r.rel_cnt >= RW'(RELEASE_CYC - 1)) begin
        st_nxt.fault = 1'b0;
        st_nxt.rel_cnt = '0;
      end else begin
        st_nxt.rel_cnt = st_r.rel_cnt + RW'(1);
      end
    end else begin
      st_nxt.rel_cnt = '0;
    end
    st_nxt.irq = st_nxt.fault && irq_enable_i;
    st_nxt.rdata = '0;
    if (sfr_req_i.addr == `SMON_REG_ADDR) begin
      st_nxt.rdata[`SMON_BIT_DIG_OK] = st_r.dig_ok;
      st_nxt.rdata[`SMON_BIT_ANA_OK] = st_r.ana_ok;
      st_nxt.rdata[`SMON_BIT_FAULT] = st_r.fault;
      st_nxt.rdata[`SMON_BIT_DTRIP_HI:`SMON_BIT_DTRIP_LO] = st_r.dig_trip;
      st_nxt.rdata[`SMON_BIT_ATRIP_HI:`SMON_BIT_ATRIP_LO] = st_r.ana_trip;
      st_nxt.rdata[`SMON_BIT_ON] = st_r.enable;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
      st_r.dig_sync <= 2'h3;
      st_r.ana_sync <= 2'h3;
      st_r.dig_ok <= 1'(`SMON_REG_RESET >> `SMON_BIT_DIG_OK);
      st_r.ana_ok <= 1'(`SMON_REG_RESET >> `SMON_BIT_ANA_OK);
      st_r.fault <= 1'(`SMON_REG_RESET >> `SMON_BIT_FAULT);
      st_r.dig_trip <= trip_level_t'(2'h3);
      st_r.ana_trip <= trip_level_t'(2'h3);
      st_r.enable <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sfr_rdata_o = st_r.rdata;
  assign irq_o = st_r.irq;
  assign comp_ctrl_o.dig_trip = st_r.dig_trip;
  assign comp_ctrl_o.ana_trip = st_r.ana_trip;
  assign comp_ctrl_o.enable = st_r.enable;
endmodule

// ---- hw/supply_monitor_params.svh ----
// Offsets, field positions, reset values and timing counts of the supply monitor
`ifndef SUPPLY_MONITOR_PARAMS_SVH
`define SUPPLY_MONITOR_PARAMS_SVH
`define SMON_REG_ADDR 8'hdf
`define SMON_REG_RESET 8'hde
`define SMON_BIT_DIG_OK 7
`define SMON_BIT_ANA_OK 6
`define SMON_BIT_FAULT 5
`define SMON_BIT_DTRIP_HI 4
`define SMON_BIT_DTRIP_LO 3
`define SMON_BIT_ATRIP_HI 2
`define SMON_BIT_ATRIP_LO 1
`define SMON_BIT_ON 0
`define SMON_CLK_HZ 250000000
`define SMON_RELEASE_MS 250
`define SMON_RELEASE_CYC ((`SMON_CLK_HZ / 1000) * `SMON_RELEASE_MS)
`define SMON_GLITCH_NS 100
`define SMON_GLITCH_CYC ((`SMON_GLITCH_NS * (`SMON_CLK_HZ / 1000000) + 999) / 1000)
`endif

// ---- hw/supply_monitor_pkg.sv ----
// Types shared by the supply monitor flag logic
package supply_monitor_pkg;
  typedef enum logic [1:0] {
    TRIP_4V63,
    TRIP_3V08,
    TRIP_2V93,
    TRIP_2V63
  } trip_level_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    trip_level_t dig_trip;
    trip_level_t ana_trip;
    logic enable;
  } comp_ctrl_t;
endpackage

// ---- verification/cmp_model.sv ----
// Comparator pair standing in for the supply sensing
`timescale 1ns/1ps
module cmp_model (
  input wire logic [1:0] good_i, // Supply good, digital then analog
  input wire supply_monitor_pkg::comp_ctrl_t ctl_i, // Control
  output logic dig_o, // Digital comparator
  output logic ana_o // Analog comparator
);
  assign dig_o = good_i[1] | ~ctl_i.enable;
  assign ana_o = good_i[0] | ~ctl_i.enable;
endmodule

// ---- verification/supply_monitor_assertions.sv ----
// Port checks for the supply monitor flag logic
`timescale 1ns/1ps
module supply_monitor_checker #(
  parameter int unsigned RELEASE_CYC = 20,
  parameter int unsigned GLITCH_CYC = 3
) (
  input wire logic ref_clk_i, // Clock
  input wire logic reset_n_i, // Reset
  input wire supply_monitor_pkg::sfr_req_t sfr_req_i, // Request
  input wire logic [7:0] sfr_rdata_o, // Read data
  input wire logic digital_supply_cmp_i, // Digital comparator
  input wire logic analog_supply_cmp_i, // Analog comparator
  input wire logic irq_enable_i, // Irq enable
  input wire supply_monitor_pkg::comp_ctrl_t comp_ctrl_o, // Comparator control
  input wire logic irq_o // Irq
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire wr = sfr_req_i.wr && sfr_req_i.addr == 8'hdf;
  wire [7:0] d = sfr_req_i.wdata;
  wire on = comp_ctrl_o.enable;
  wire rd = sfr_req_i.addr == 8'hdf;
  // Longer than the filter window, so a real drop
  sequence s_low; (on && !analog_supply_cmp_i)[*8]; endsequence
  property p_dtrip; wr |=> comp_ctrl_o.dig_trip == $past(d[4:3]); endproperty
  a_dtrip: assert property (p_dtrip) else $error("dig trip");
  property p_atrip; wr |=> comp_ctrl_o.ana_trip == $past(d[2:1]); endproperty
  a_atrip: assert property (p_atrip) else $error("ana trip");
  property p_on; wr |=> on == $past(d[0]); endproperty
  a_on: assert property (p_on) else $error("enable");
  property p_fault; s_low ##1 irq_enable_i[*2] |=> irq_o; endproperty
  a_fault: assert property (p_fault) else $error("no irq");
  property p_alo; s_low ##0 rd |=> !sfr_rdata_o[6]; endproperty
  a_alo: assert property (p_alo) else $error("ana status");
  property p_ok;
    (on && digital_supply_cmp_i && analog_supply_cmp_i && rd)[*6] |=> sfr_rdata_o[7:6] == 2'h3;
  endproperty
  a_ok: assert property (p_ok) else $error("status");
  property p_gate; !$past(irq_enable_i) |-> !irq_o; endproperty
  a_gate: assert property (p_gate) else $error("irq gate");
  property p_rel;
    $fell(irq_o) && $past(irq_enable_i) && on |-> $past(digital_supply_cmp_i && analog_supply_cmp_i, 4);
  endproperty
  a_rel: assert property (p_rel) else $error("early clear");
endmodule
bind supply_monitor_flag_logic supply_monitor_checker #(.RELEASE_CYC(RELEASE_CYC),
  .GLITCH_CYC(GLITCH_CYC)) i_chk (.*);

// ---- verification/testbench.sv ----
// Self-checking bench for the supply monitor flag logic
`timescale 1ns/1ps
module testbench;
  import supply_monitor_pkg::*;
  logic ref_clk_i = 0, reset_n_i = 0, irq_en = 1, irq_o, dig, ana;
  logic [1:0] good = 2'h3;
  logic [7:0] rdata;
  sfr_req_t req = '{8'hdf, 1'b0, 8'h00};
  comp_ctrl_t ctl;
  int num_errors = 0, total_checks = 0, cyc = 0;
  logic [15:0] rows [4] = '{16'h01c1, 16'h0bcb, 16'h15d5, 16'h1fdf};
  supply_monitor_flag_logic #(.RELEASE_CYC(20), .GLITCH_CYC(3)) i_supply_monitor_flag_logic (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .sfr_req_i(req), .sfr_rdata_o(rdata),
    .digital_supply_cmp_i(dig), .analog_supply_cmp_i(ana), .irq_enable_i(irq_en),
    .comp_ctrl_o(ctl), .irq_o(irq_o));
  cmp_model i_cmp_model (.good_i(good), .ctl_i(ctl), .dig_o(dig), .ana_o(ana));
  initial forever #2 ref_clk_i = ~ref_clk_i;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc > 2000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    wt(16);
    chk(rdata, 8'h00);
    reset_n_i = 1;
    wt(2);
    chk(rdata, 8'hde);
    foreach (rows[k]) begin
      req = '{8'hdf, 1'b1, rows[k][15:8]};
      wt(1);
      req.wr = 0;
      wt(2);
      chk(rdata, rows[k][7:0]);
      chk({3'h0, ctl}, {3'h0, rows[k][12:8]});
    end
    good = 2'h2;
    wt(2);
    good = 2'h3;
    wt(8);
    chk({7'h0, irq_o}, 8'h00);
    good = 2'h2;
    wt(12);
    chk({7'h0, irq_o}, 8'h01);
    req = '{8'hdf, 1'b1, 8'h1f};
    wt(1);
    req.wr = 0;
    wt(2);
    chk(rdata, 8'hbf);
    irq_en = 0;
    wt(2);
    chk({7'h0, irq_o}, 8'h00);
    irq_en = 1;
    good = 2'h3;
    wt(15);
    good = 2'h2;
    wt(8);
    good = 2'h3;
    wt(15);
    chk({7'h0, irq_o}, 8'h01);
    wt(12);
    chk({7'h0, irq_o}, 8'h00);
    good = 2'h1;
    wt(12);
    chk(rdata, 8'h7f);
    good = 2'h3;
    wt(6);
    req = '{8'hdf, 1'b1, 8'h1f};
    wt(1);
    req.wr = 0;
    wt(2);
    chk(rdata, 8'hdf);
    chk({7'h0, irq_o}, 8'h00);
    req.addr = 8'h00;
    wt(2);
    chk(rdata, 8'h00);
    close_out();
  end
endmodule
